// ==== rcd_dbg_host.sv ====
// Debug host model: serial writes into the force-reset register.
// Assumes the bench clock; one write per call.
`timescale 1ns/1ps
`default_nettype none
module rcd_dbg_host (
	// Clock
	input  wire logic       clock_i,
	// Debug write path and mode pin
	output logic            dbg_wr_o,
	output logic      [1:0] dbg_addr_o,
	output logic      [7:0] dbg_wdata_o,
	output logic            mode_select_o
);
	// Idle link, user mode requested
	initial begin
		dbg_wr_o = 1'h0;
		dbg_addr_o = 2'h3;
		dbg_wdata_o = 8'hA5;
		mode_select_o = 1'h1;
	end
	// Only this path writes the force register
	task automatic write_byte(input logic [1:0] a, input logic [7:0] d);
		@(posedge clock_i) #1;
		dbg_wr_o = 1'h1;
		dbg_addr_o = a;
		dbg_wdata_o = d;
		@(posedge clock_i) #1;
		dbg_wr_o = 1'h0;
		dbg_addr_o = ~a;
		dbg_wdata_o = ~d;
		mode_select_o = 1'h1; // High after the write: user mode
	endtask
endmodule
`default_nettype wire

// ==== rcd_pkg.sv ====
// Constants for the reset-cause and debug force-reset block.
// Assumes a single bus clock; offsets are local to this block.
package rcd_pkg;
	// Register offsets within this block
	localparam logic [1:0] RCD_OFF_CAUSE = 2'h0;
	localparam logic [1:0] RCD_OFF_FORCE = 2'h1;
	// Field positions of the cause register
	localparam int RCD_BIT_POWER_ON = 7;
	localparam int RCD_BIT_PIN      = 6;
	localparam int RCD_BIT_WATCHDOG = 5;
	localparam int RCD_BIT_ILL_OP   = 4;
	localparam int RCD_BIT_ILL_ADDR = 3;
	localparam int RCD_BIT_SUPPLY   = 1;
	localparam int RCD_BIT_FORCE    = 0;
	// Reset values
	localparam logic [7:0] RCD_CAUSE_POR   = 8'h82;
	localparam logic [7:0] RCD_CAUSE_CLEAR = 8'h00;
	localparam logic [7:0] RCD_FORCE_READ  = 8'h00;
	// Length of the forced-reset pulse in cycles
	localparam logic [1:0] RCD_FORCE_CYCLES = 2'h2;
endpackage

// ==== rcd_reset_cause.sv ====
// Reset-cause flag register and debug force-reset register.
// Assumes reset sources arrive as synchronous levels from the system.
`timescale 1ns/1ps
`default_nettype none
module rcd_reset_cause
	import rcd_pkg::*;
(
	// Clock and power-on reset
	input  wire logic       clock_i,
	input  wire logic       rst_n_i,
	// Reset sources, levels at reset entry
	input  wire logic       supply_low_i,
	input  wire logic       supply_drop_reset_enable,
	input  wire logic       reset_pin_n_i,
	input  wire logic       watchdog_timeout_i,
	input  wire logic       watchdog_enable,
	input  wire logic       illegal_opcode_i,
	input  wire logic       stop_exec_i,
	input  wire logic       stop_allow_bit,
	input  wire logic       enter_debug_instruction,
	input  wire logic       debug_mode_allow,
	input  wire logic       illegal_address_i,
	// User register port
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	input  wire logic [1:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	// Debug link write port
	input  wire logic       dbg_wr_i,
	input  wire logic [1:0] dbg_addr_i,
	input  wire logic [7:0] dbg_wdata_i,
	// Outputs
	output logic      [7:0] reg_rdata_o,
	output logic            watchdog_restart_o,
	output logic            system_reset_o
);
	// Behaviour overview
	// The cause byte is loaded once per reset entry. A source that stays
	// active keeps the block in reset, and in_reset_r stops a second load,
	// so the flags name the sources seen on the first cycle of the reset.
	// A supply drop is handled apart from the other sources: it sets the
	// supply flag, clears the pin, watchdog and illegal flags, and leaves
	// the power-on flag as it was.
	// A forced reset from the debug link wins over every other source in
	// the same cycle, but a supply drop held into the next cycle reloads the flags over its clearing.
	// User writes reach only the watchdog restart; their data is unused,
	// since any value restarts the watchdog.
	// Limitation: power-on is carried by rst_n_i alone, so the system
	// around this block must assert that input for power-on only.
	// Trade-off: read data is registered, one cycle of latency bought
	// to keep the read mux off the bus timing path.
	// Flag register and pulse counter
	logic [7:0] reset_cause_reg_r;
	logic [1:0] force_cnt_r;
	logic       in_reset_r;
	// Decoded causes
	logic       op_illegal;
	logic       any_src;
	logic       debug_force_reset_bit;
	// Capture allowed: not held in reset, no force, no supply drop
	logic       capture_ok;

	// Illegal-opcode sources, stop and debug entry included
	assign op_illegal = illegal_opcode_i
		| (stop_exec_i & ~stop_allow_bit)
		| (enter_debug_instruction & ~debug_mode_allow);
	// Debug-only force write; user writes never reach it
	assign debug_force_reset_bit = dbg_wr_i
		& (dbg_addr_i == RCD_OFF_FORCE)
		& dbg_wdata_i[RCD_BIT_FORCE];
	// Any source that starts a reset this cycle
	assign any_src = ~reset_pin_n_i
		| (watchdog_timeout_i & watchdog_enable)
		| op_illegal | illegal_address_i
		| (supply_low_i & supply_drop_reset_enable);
	// Qualifier shared by the per-flag checks below
	assign capture_ok = !in_reset_r && !debug_force_reset_bit
		&& !(supply_low_i && supply_drop_reset_enable);

	// Address decode shared by the write, read and check paths
	function automatic logic addr_is(input logic [1:0] a,
		input logic [1:0] off);
		addr_is = (a == off);
	endfunction

	// Flag capture at reset entry; held otherwise
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			reset_cause_reg_r <= RCD_CAUSE_POR;
		end else if (debug_force_reset_bit) begin
			reset_cause_reg_r <= RCD_CAUSE_CLEAR;
		end else if (supply_low_i & supply_drop_reset_enable) begin
			// Supply drop keeps power-on flag, sets supply flag, clears others
			reset_cause_reg_r <= (reset_cause_reg_r
				& (8'h01 << RCD_BIT_POWER_ON))
				| (8'h01 << RCD_BIT_SUPPLY);
		end else if (any_src && !in_reset_r) begin
			// Latch active sources only, clear the rest
			reset_cause_reg_r <= RCD_CAUSE_CLEAR;
			reset_cause_reg_r[RCD_BIT_PIN] <= ~reset_pin_n_i;
			reset_cause_reg_r[RCD_BIT_WATCHDOG] <=
				watchdog_timeout_i & watchdog_enable;
			reset_cause_reg_r[RCD_BIT_ILL_OP] <= op_illegal;
			reset_cause_reg_r[RCD_BIT_ILL_ADDR] <=
				illegal_address_i;
		end
		// Writes from the user port never alter flags
	end

	// Reset-held marker so a long source latches once
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			in_reset_r <= 1'b1;
		end else begin
			in_reset_r <= any_src | (force_cnt_r != 2'h0);
		end
	end

	// Forced reset pulse counter
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			force_cnt_r <= 2'h0;
		end else if (debug_force_reset_bit) begin
			force_cnt_r <= RCD_FORCE_CYCLES;
		end else if (force_cnt_r != 2'h0) begin
			force_cnt_r <= force_cnt_r - 2'h1;
		end
	end

	// System reset request: any source or forced pulse
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			system_reset_o <= 1'b0;
		end else begin
			system_reset_o <= any_src | debug_force_reset_bit
				| (force_cnt_r > 2'h1);
		end
	end

	// Watchdog restart pulse on any user cause write
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			watchdog_restart_o <= 1'b0;
		end else begin
			watchdog_restart_o <= reg_wr_i
				& addr_is(reg_addr_i, RCD_OFF_CAUSE);
		end
	end

	// Read data; force register and unmapped read zero
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i && addr_is(reg_addr_i, RCD_OFF_CAUSE)) begin
			reg_rdata_o <= reset_cause_reg_r & 8'hFA;
		end else begin
			reg_rdata_o <= RCD_FORCE_READ;
		end
	end

	// Checks
	chk_flags_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(!any_src && !debug_force_reset_bit) |=> $stable(reset_cause_reg_r))
		else $error("cause flags changed without a reset");
	chk_force_clear: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		debug_force_reset_bit |=> reset_cause_reg_r == 8'h00)
		else $error("forced reset did not clear flags");
	chk_wd_restart: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(reg_wr_i && reg_addr_i == RCD_OFF_CAUSE) |=> watchdog_restart_o)
		else $error("cause write did not restart watchdog");
	chk_force_reads: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(reg_rd_i && reg_addr_i == RCD_OFF_FORCE) |=> reg_rdata_o == 8'h00)
		else $error("force register read nonzero");
	chk_force_pulse: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		debug_force_reset_bit |=> system_reset_o [*2])
		else $error("forced reset pulse too short");
	chk_stop_illegal: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(stop_exec_i && !stop_allow_bit && !in_reset_r && !debug_force_reset_bit
		&& !(supply_low_i && supply_drop_reset_enable))
		|=> reset_cause_reg_r[RCD_BIT_ILL_OP])
		else $error("stop not flagged illegal");
	chk_pin_flag: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(!reset_pin_n_i && !in_reset_r && !debug_force_reset_bit
		&& !(supply_low_i && supply_drop_reset_enable))
		|=> reset_cause_reg_r[RCD_BIT_PIN])
		else $error("pin reset not flagged");
	chk_zero_bits: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		reg_rd_i |=> (reg_rdata_o[2] == 1'b0 && reg_rdata_o[0] == 1'b0))
		else $error("reserved cause bits read nonzero");

	// Power-on value must be present on the first cycle out of reset
	// Caught here since no other check runs while reset is held
	chk_por_value: assert property (@(posedge clock_i)
		$rose(rst_n_i) |-> reset_cause_reg_r == RCD_CAUSE_POR)
		else $error("power-on flags wrong after reset");
	// Supply drop sets its flag and clears pin, watchdog, illegal flags
	chk_supply_flag: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		(supply_low_i && supply_drop_reset_enable && !debug_force_reset_bit)
		|=> (reset_cause_reg_r[RCD_BIT_SUPPLY]
		&& reset_cause_reg_r[RCD_BIT_PIN:RCD_BIT_ILL_ADDR] == 4'h0))
		else $error("supply drop flags wrong");
	// Supply drop leaves the power-on flag as it was
	chk_supply_keep_por: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		(supply_low_i && supply_drop_reset_enable && !debug_force_reset_bit)
		|=> reset_cause_reg_r[RCD_BIT_POWER_ON]
		== $past(reset_cause_reg_r[RCD_BIT_POWER_ON]))
		else $error("supply drop changed power-on flag");
	// Any other reset clears the power-on and supply flags
	chk_other_clears: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		(any_src && capture_ok)
		|=> (!reset_cause_reg_r[RCD_BIT_POWER_ON]
		&& !reset_cause_reg_r[RCD_BIT_SUPPLY]))
		else $error("other reset kept power flags");
	// Inactive pin source leaves its flag clear
	chk_pin_clear: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		(any_src && capture_ok && reset_pin_n_i)
		|=> !reset_cause_reg_r[RCD_BIT_PIN])
		else $error("pin flag set without pin reset");
	// Inactive address source leaves its flag clear
	chk_illegal_address_flag_clear: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		(any_src && capture_ok && !illegal_address_i)
		|=> !reset_cause_reg_r[RCD_BIT_ILL_ADDR])
		else $error("address flag set without source");
	// A source held over many cycles is latched only once
	chk_latch_once: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		(any_src && in_reset_r && !debug_force_reset_bit
		&& !(supply_low_i && supply_drop_reset_enable))
		|=> $stable(reset_cause_reg_r))
		else $error("flags reloaded during held reset");
	// Enabled watchdog timeout sets its flag
	chk_wd_flag: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		(watchdog_timeout_i && watchdog_enable && capture_ok)
		|=> reset_cause_reg_r[RCD_BIT_WATCHDOG])
		else $error("watchdog reset not flagged");
	// No reset request without a qualified source or a forced pulse
	// Guards the enables: a blocked watchdog or supply must stay quiet
	chk_no_spurious: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		(!any_src && !debug_force_reset_bit && force_cnt_r <= 2'h1)
		|=> !system_reset_o)
		else $error("reset requested without a source");
	// Illegal opcode sets its flag
	chk_illegal_opcode_flag_flag: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		(illegal_opcode_i && capture_ok)
		|=> reset_cause_reg_r[RCD_BIT_ILL_OP])
		else $error("illegal opcode not flagged");
	// Enter-debug without permission counts as illegal opcode
	chk_debug_illegal: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		(enter_debug_instruction && !debug_mode_allow && capture_ok)
		|=> reset_cause_reg_r[RCD_BIT_ILL_OP])
		else $error("enter-debug not flagged illegal");
	// Illegal address sets its flag
	chk_illegal_address_flag_flag: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		(illegal_address_i && capture_ok)
		|=> reset_cause_reg_r[RCD_BIT_ILL_ADDR])
		else $error("illegal address not flagged");
	// A debug write of zero leaves the flags as they were
	chk_zero_force: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		(dbg_wr_i && addr_is(dbg_addr_i, RCD_OFF_FORCE)
		&& !dbg_wdata_i[RCD_BIT_FORCE] && !any_src)
		|=> $stable(reset_cause_reg_r))
		else $error("zero force write changed flags");
	// Forced pulse ends after two cycles when nothing else is active
	chk_force_end: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		debug_force_reset_bit ##1 !debug_force_reset_bit
		##1 (!debug_force_reset_bit && !any_src)
		|=> !system_reset_o)
		else $error("forced reset pulse too long");
	// Cause read returns the stored flags in their documented places
	chk_rdata_flags: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		(reg_rd_i && addr_is(reg_addr_i, RCD_OFF_CAUSE))
		|=> (reg_rdata_o[7:3] == $past(reset_cause_reg_r[7:3])
		&& reg_rdata_o[1] == $past(reset_cause_reg_r[1])))
		else $error("cause read data wrong");
	// Restart pulses only after a cause-register write
	chk_restart_only: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		!(reg_wr_i && addr_is(reg_addr_i, RCD_OFF_CAUSE))
		|=> !watchdog_restart_o)
		else $error("watchdog restart without write");
	// User writes never change the flags
	chk_user_write_kept: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		(reg_wr_i && !any_src && !debug_force_reset_bit)
		|=> $stable(reset_cause_reg_r))
		else $error("user write changed flags");
endmodule
`default_nettype wire

// ==== reset_cause_and_debug_force_reset_tb_top.sv ====
// Bench for the reset-cause block: sources, user and debug writes.
// Assumes the debug host model; assertions sit in the design.
`timescale 1ns/1ps
`default_nettype none
module reset_cause_and_debug_force_reset_tb_top;
	import rcd_pkg::*;
	logic       clock_i = 1'h0;
	logic       rst_n_i = 1'h0;
	logic [6:0] src = 7'h00;  // Reset source levels
	logic [3:0] en = 4'h0;    // Option bits
	logic       rd = 1'h0, wr = 1'h0;
	logic [1:0] addr = 2'h0, dbg_addr;
	logic [7:0] wdata = 8'h00, rdata, dbg_wdata;
	logic       restart, sysrst, dbg_wr;
	int         fail_count = 0, num_checks = 0;
	// Source, option and expected flags for each cause
	logic [6:0] t_src [11] = '{7'h01, 7'h02, 7'h02, 7'h04, 7'h20, 7'h08,
		7'h08, 7'h40, 7'h40, 7'h10, 7'h10};
	logic [3:0] t_en [11] = '{4'h0, 4'h1, 4'h0, 4'h0, 4'h0, 4'h2, 4'h0,
		4'h8, 4'h0, 4'h4, 4'h0};
	logic [7:0] t_exp [11] = '{8'h40, 8'h20, 8'h20, 8'h10, 8'h08, 8'h08,
		8'h10, 8'h02, 8'h02, 8'h02, 8'h10};
	always #2.5 clock_i = ~clock_i;
	rcd_reset_cause u_rcd_reset_cause (
		.clock_i(clock_i), .rst_n_i(rst_n_i),
		.supply_low_i(src[6]), .supply_drop_reset_enable(en[3]),
		.reset_pin_n_i(!src[0]), .watchdog_timeout_i(src[1]),
		.watchdog_enable(en[0]), .illegal_opcode_i(src[2]),
		.stop_exec_i(src[3]), .stop_allow_bit(en[1]),
		.enter_debug_instruction(src[4]), .debug_mode_allow(en[2]),
		.illegal_address_i(src[5]), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .dbg_wr_i(dbg_wr),
		.dbg_addr_i(dbg_addr), .dbg_wdata_i(dbg_wdata),
		.reg_rdata_o(rdata), .watchdog_restart_o(restart),
		.system_reset_o(sysrst));
	rcd_dbg_host u_rcd_dbg_host (.clock_i(clock_i), .dbg_wr_o(dbg_wr),
		.dbg_addr_o(dbg_addr), .dbg_wdata_o(dbg_wdata), .mode_select_o());
	task automatic check(input string n, input logic [7:0] s, e);
		num_checks++;
		if (s !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	// One user strobe; answer is settled on return
	task automatic rw(input logic w, input logic [1:0] a, input logic [7:0] d);
		@(posedge clock_i) #1;
		wr = w;
		rd = !w;
		addr = a;
		wdata = d;
		@(posedge clock_i) #1;
		wr = 1'h0;
		rd = 1'h0;
	endtask
	task automatic t_user;
		rw(0, RCD_OFF_CAUSE, 8'h00);
		check("por", rdata, RCD_CAUSE_POR);
		rw(1, RCD_OFF_CAUSE, 8'hFF);
		check("restart", restart, 1'h1);
		rw(1, RCD_OFF_FORCE, 8'hFF);
		check("user force", sysrst, 1'h0);
		rw(0, RCD_OFF_FORCE, 8'h00);
		check("force read", rdata, RCD_FORCE_READ);
		rw(0, RCD_OFF_CAUSE, 8'h00);
		check("kept", rdata, RCD_CAUSE_POR);
	endtask
	task automatic t_force;
		u_rcd_dbg_host.write_byte(RCD_OFF_FORCE, 8'h00);
		check("zero write", sysrst, 1'h0);
		u_rcd_dbg_host.write_byte(RCD_OFF_FORCE, 8'h01);
		check("force c1", sysrst, 1'h1);
		@(posedge clock_i) #1;
		check("force c2", sysrst, 1'h1);
		@(posedge clock_i) #1;
		check("force c3", sysrst, 1'h0);
		rw(0, RCD_OFF_CAUSE, 8'h00);
		check("cleared", rdata, RCD_CAUSE_CLEAR);
	endtask
	// Disabled sources must leave the previous flags standing
	task automatic t_causes;
		for (int i = 0; i < 11; i++) begin
			@(posedge clock_i) #1;
			src = t_src[i];
			en = t_en[i];
			@(posedge clock_i) #1;
			src = 7'h00;
			repeat (3) @(posedge clock_i);
			for (int k = 0; k < 16 && sysrst !== 1'h0; k++) @(posedge clock_i);
			rw(0, RCD_OFF_CAUSE, 8'h00);
			check("cause", rdata, t_exp[i]);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clock_i) #1;
		rst_n_i = 1'h1;
		t_user();
		t_force();
		t_causes();
		conclude();
	end
	// Run needs well under 500 cycles
	initial begin
		#10000;
		fail_count++;
		conclude();
	end
endmodule
`default_nettype wire
